// [adc_if_pkg.sv]
// Purpose: Shared constants and pin bundle for the imaging converter digital side
// Assumes: One system clock at 25 MHz; every device pin is asynchronous to it
// Notes:   Bit positions refer to the two control bytes written over the serial port
package adc_if_pkg;

   // ****************************************
   // Widths and timing
   // ****************************************
   localparam int CODE_W           = 14;    // Converter code width
   localparam int CODE_COUNT       = 16384; // Distinct codes, all reachable
   localparam int PIPE_DEPTH       = 9;     // Sample clocks from capture to output
   localparam int CLK_MHZ          = 25;    // System clock rate
   localparam int SAMPLE_PERIOD_NS = 18;    // Typical sample clock period (far side)
   localparam int CLAMP_PIXELS     = 20;    // Typical clamp pulse width in pixels
   localparam int SERIAL_FMAX_MHZ  = 10;    // Highest serial clock rate
   localparam int RESET_HOLD_US    = 10;    // Least reset pulse after power-up
   localparam int RESET_HOLD_CYC   = RESET_HOLD_US * CLK_MHZ; // Least time, whole cycles
   localparam int BYTE_W           = 8;     // Serial byte width

   // ****************************************
   // Control byte layout and reset values
   // ****************************************
   localparam int PARTSEL_BIT   = 0; // Byte 0: must be 1 to accept a write
   localparam int OPMODE_LSB    = 1; // Byte 0: two-bit operating mode
   localparam int EDGE_SEL_BIT  = 4; // Byte 0: 0 rising, 1 falling output update
   localparam int FAST_CLP_BIT  = 5; // Byte 0: fast clamp
   localparam int OUT_DIS_BIT   = 7; // Byte 0: data outputs released
   localparam int CLAMP_DIS_BIT = 6; // Byte 1: black clamp disabled
   localparam logic [7:0] CTRL0_RESET = 8'h03;
   localparam logic [7:0] CTRL1_RESET = 8'h00;

   // ****************************************
   // Pin bundle sampled into the clock domain
   // ****************************************
   typedef struct packed
   {
      logic              sampleClock;
      logic              blackClampPulse;
      logic              preblankPulse;
      logic              serialClock;
      logic              serialDataIn;
      logic              serialLoadN;
      logic              registerResetN;
      logic [CODE_W-1:0] conversionCode;
   } pins_s;

endpackage

// [imaging_adc_digital_interface.sv]
// Purpose: Digital side of a 14-bit imaging front end: sample pipeline, clamp, serial port
// Assumes: All pins oversampled by clk; sample and serial clocks far slower than clk
// Notes:   A typical 18 ns sample clock cannot be oversampled at 25 MHz; real silicon
//          would clock the pipe from the pin, here the edges are detected
// What this block does
// - Each sample clock rising edge captures one sample
// - Codes are 14 bits, all values pass
// - Output words change only with sample clock
// - Clamp pulse enables black clamp while high
// - Reset pin low restores control defaults
// - Serial bits taken on serial clock rise
// - LSB-first bytes commit on load line rise
// - Control bit picks rising or falling update
`timescale 1ns/1ps
module imaging_adc_digital_interface
(
   input  wire logic                            clk,
   input  wire logic                            arst_n,
   input  wire logic                            sampleClock,
   input  wire logic                            blackClampPulse,
   input  wire logic                            preblankPulse,
   input  wire logic                            serialClock,
   input  wire logic                            serialDataIn,
   input  wire logic                            serialLoadN,
   input  wire logic                            registerResetN,
   input  wire logic [adc_if_pkg::CODE_W-1:0]   conversionCode,
   output logic      [adc_if_pkg::CODE_W-1:0]   sampleWordOut,
   output logic                                 sampleWordOutEn,
   output logic                                 clampActive,
   output logic      [7:0]                      clampWidth,
   output logic      [7:0]                      controlByte0,
   output logic      [7:0]                      controlByte1
);

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   logic                rstMeta_reg; // First reset release stage
   logic                rstN;        // Released reset used everywhere
   adc_if_pkg::pins_s   pinsRaw;     // Pins as they arrive
   adc_if_pkg::pins_s   pinsSync;    // Pins after two flops

   // Reset asserts at once, releases after two edges
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rstMeta_reg <= 1'b0;
         rstN        <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstN        <= rstMeta_reg;
      end
   end

   assign pinsRaw = '{sampleClock, blackClampPulse, preblankPulse, serialClock,
                      serialDataIn, serialLoadN, registerResetN, conversionCode};

   // Two-flop synchroniser; its first stage stays private
   sample_pipe #(.WIDTH($bits(adc_if_pkg::pins_s)), .DEPTH(2)) u_pinSync
   (
      .clk     (clk),
      .rstN    (rstN),
      .shiftEn (1'b1),
      .dataIn  (pinsRaw),
      .headOut (),
      .tailOut (pinsSync)
   );

   // ****************************************
   // Edge detection
   // ****************************************
   logic prevSample_reg, prevSck_reg, prevLoad_reg; // Last synced levels
   logic sampleRise, sampleFall, sckRise, loadRise, loadFall;

   assign sampleRise = pinsSync.sampleClock & ~prevSample_reg;
   assign sampleFall = ~pinsSync.sampleClock & prevSample_reg;
   assign sckRise    = pinsSync.serialClock & ~prevSck_reg;
   assign loadRise   = pinsSync.serialLoadN & ~prevLoad_reg;
   assign loadFall   = ~pinsSync.serialLoadN & prevLoad_reg;

   // ****************************************
   // Sample pipeline
   // ****************************************
   logic [adc_if_pkg::CODE_W-1:0] headWord; // Word taken at the last rising edge
   logic [adc_if_pkg::CODE_W-1:0] pipeTail; // Word nine edges old

   // One stage per rising edge, full code width kept untouched
   sample_pipe #(.WIDTH(adc_if_pkg::CODE_W), .DEPTH(adc_if_pkg::PIPE_DEPTH)) u_pipe
   (
      .clk     (clk),
      .rstN    (rstN),
      .shiftEn (sampleRise),
      .dataIn  (pinsSync.conversionCode),
      .headOut (headWord),
      .tailOut (pipeTail)
   );

   // ****************************************
   // Output, clamp and serial state
   // ****************************************
   logic [adc_if_pkg::CODE_W-1:0] word_reg, word_next;   // Output bus
   logic                          outEn_reg, outEn_next; // Bus drive enable
   logic                          clamp_reg, clamp_next; // Clamp enable
   logic [7:0]                    clampW_reg, clampW_next; // Pixels in clamp
   logic [7:0]                    ctrl0_reg, ctrl0_next;   // Control byte 0
   logic [7:0]                    ctrl1_reg, ctrl1_next;   // Control byte 1
   logic [7:0]                    shift_reg, shift_next;   // Serial shifter
   logic [2:0]                    bitCnt_reg, bitCnt_next; // Bits in this byte
   logic [1:0]                    byteCnt_reg, byteCnt_next; // Whole bytes seen
   logic [7:0]                    pend0_reg, pend0_next;   // Byte 0 awaiting commit
   logic [7:0]                    pend1_reg, pend1_next;   // Byte 1 awaiting commit
   logic                          edgeSel;                 // Output update edge

   assign edgeSel = ctrl0_reg[adc_if_pkg::EDGE_SEL_BIT];

   // Next state of every group
   always_comb
   begin
      word_next    = word_reg;
      outEn_next   = ~ctrl0_reg[adc_if_pkg::OUT_DIS_BIT];
      ctrl0_next   = ctrl0_reg;
      ctrl1_next   = ctrl1_reg;
      shift_next   = shift_reg;
      bitCnt_next  = bitCnt_reg;
      byteCnt_next = byteCnt_reg;
      pend0_next   = pend0_reg;
      pend1_next   = pend1_reg;
      // Update only on the chosen sample clock edge
      if ((!edgeSel && sampleRise) || (edgeSel && sampleFall))
      begin
         word_next = pipeTail;
      end
      // Clamp follows the pulse unless disabled
      clamp_next  = pinsSync.blackClampPulse & ~ctrl1_reg[adc_if_pkg::CLAMP_DIS_BIT];
      clampW_next = clampW_reg;
      if (!clamp_next)
      begin
         clampW_next = 8'h00;
      end
      else if (sampleRise && clampW_reg != 8'hFF)
      begin
         clampW_next = clampW_reg + 8'h01; // Saturates, so long pulses stay visible
      end
      // Serial frame: a fresh start clears partial bytes
      if (loadFall)
      begin
         bitCnt_next  = 3'h0;
         byteCnt_next = 2'h0;
      end
      else if (sckRise && !pinsSync.serialLoadN)
      begin
         // Least significant bit arrives first, so shift toward bit 0
         shift_next  = {pinsSync.serialDataIn, shift_reg[7:1]};
         bitCnt_next = bitCnt_reg + 3'h1;
         if (bitCnt_reg == 3'h7)
         begin
            if (byteCnt_reg == 2'h0)
            begin
               pend0_next = shift_next;
            end
            else if (byteCnt_reg == 2'h1)
            begin
               pend1_next = shift_next;
            end
            if (byteCnt_reg != 2'h3)
            begin
               byteCnt_next = byteCnt_reg + 2'h1; // Bytes past the map are dropped
            end
         end
      end
      // Whole bytes take effect on the load rise, byte 0 gates all
      if (loadRise && byteCnt_reg != 2'h0 && pend0_reg[adc_if_pkg::PARTSEL_BIT])
      begin
         ctrl0_next = pend0_reg;
         if (byteCnt_reg != 2'h1)
         begin
            ctrl1_next = pend1_reg;
         end
      end
      // Reset pin wins over any write
      if (!pinsSync.registerResetN)
      begin
         ctrl0_next   = adc_if_pkg::CTRL0_RESET;
         ctrl1_next   = adc_if_pkg::CTRL1_RESET;
         bitCnt_next  = 3'h0;
         byteCnt_next = 2'h0;
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         prevSample_reg <= 1'b0;
         prevSck_reg    <= 1'b0;
         prevLoad_reg   <= 1'b1;
         word_reg       <= '0;
         outEn_reg      <= 1'b0;
         clamp_reg      <= 1'b0;
         clampW_reg     <= 8'h00;
         ctrl0_reg      <= adc_if_pkg::CTRL0_RESET;
         ctrl1_reg      <= adc_if_pkg::CTRL1_RESET;
         shift_reg      <= 8'h00;
         bitCnt_reg     <= 3'h0;
         byteCnt_reg    <= 2'h0;
         pend0_reg      <= 8'h00;
         pend1_reg      <= 8'h00;
      end
      else
      begin
         prevSample_reg <= pinsSync.sampleClock;
         prevSck_reg    <= pinsSync.serialClock;
         prevLoad_reg   <= pinsSync.serialLoadN;
         word_reg       <= word_next;
         outEn_reg      <= outEn_next;
         clamp_reg      <= clamp_next;
         clampW_reg     <= clampW_next;
         ctrl0_reg      <= ctrl0_next;
         ctrl1_reg      <= ctrl1_next;
         shift_reg      <= shift_next;
         bitCnt_reg     <= bitCnt_next;
         byteCnt_reg    <= byteCnt_next;
         pend0_reg      <= pend0_next;
         pend1_reg      <= pend1_next;
      end
   end

   assign sampleWordOut   = word_reg;
   assign sampleWordOutEn = outEn_reg;
   assign clampActive     = clamp_reg;
   assign clampWidth      = clampW_reg;
   assign controlByte0    = ctrl0_reg;
   assign controlByte1    = ctrl1_reg;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_validWrite;
      loadRise && byteCnt_reg != 2'h0 && pend0_reg[adc_if_pkg::PARTSEL_BIT] &&
         pinsSync.registerResetN;
   endsequence

   property p_holdNoRise;
      @(posedge clk) disable iff (!rstN) !sampleRise |=> $stable(headWord);
   endproperty
   a_holdNoRise: assert property (p_holdNoRise) else $error("pipe moved without edge");

   property p_fullCode;
      @(posedge clk) disable iff (!rstN) sampleRise |=> headWord == $past(pinsSync.conversionCode);
   endproperty
   a_fullCode: assert property (p_fullCode) else $error("captured code altered");

   property p_outStable;
      @(posedge clk) disable iff (!rstN) !(sampleRise || sampleFall) |=> $stable(word_reg);
   endproperty
   a_outStable: assert property (p_outStable) else $error("output moved off edge");

   property p_clamp;
      @(posedge clk) disable iff (!rstN)
         pinsSync.blackClampPulse && !ctrl1_reg[adc_if_pkg::CLAMP_DIS_BIT] |=> clamp_reg;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp not enabled");

   property p_regReset;
      @(posedge clk) disable iff (!rstN)
         !pinsSync.registerResetN |=> ctrl0_reg == adc_if_pkg::CTRL0_RESET &&
            ctrl1_reg == adc_if_pkg::CTRL1_RESET;
   endproperty
   a_regReset: assert property (p_regReset) else $error("reset pin ignored");

   property p_serialBit;
      @(posedge clk) disable iff (!rstN)
         sckRise && !pinsSync.serialLoadN && !loadFall |=>
            shift_reg[7] == $past(pinsSync.serialDataIn);
   endproperty
   a_serialBit: assert property (p_serialBit) else $error("serial bit lost");

   property p_rising;
      @(posedge clk) disable iff (!rstN) !edgeSel && sampleRise |=> word_reg == $past(pipeTail);
   endproperty
   a_rising: assert property (p_rising) else $error("rising update wrong");

   property p_commit;
      @(posedge clk) disable iff (!rstN) s_validWrite |=> ctrl0_reg == $past(pend0_reg);
   endproperty
   a_commit: assert property (p_commit) else $error("write not committed");

   property p_falling;
      @(posedge clk) disable iff (!rstN) edgeSel && sampleFall |=> word_reg == $past(pipeTail);
   endproperty
   a_falling: assert property (p_falling) else $error("falling update wrong");

   property p_fallOnly;
      @(posedge clk) disable iff (!rstN)
         edgeSel && sampleRise && !$changed(ctrl0_reg) |=> $stable(word_reg);
   endproperty
   a_fallOnly: assert property (p_fallOnly) else $error("rise moved falling word");

endmodule

// [sample_pipe.sv]
// Purpose: Enabled shift line, used as pin synchroniser and as sample pipeline
// Assumes: Asynchronous active-low reset already released cleanly by the caller
// Notes:   Head is the first stage; a synchroniser must leave it unconnected
`timescale 1ns/1ps
module sample_pipe
#(
   parameter int WIDTH = 14,
   parameter int DEPTH = 9
)
(
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             shiftEn,
   input  wire logic [WIDTH-1:0] dataIn,
   output logic      [WIDTH-1:0] headOut,
   output logic      [WIDTH-1:0] tailOut
);

   // ****************************************
   // Elaboration check
   // ****************************************
   if (DEPTH < 2 || WIDTH < 1)
   begin : g_badParams
      $error("sample_pipe needs DEPTH of at least 2");
   end

   logic [WIDTH-1:0] stage_reg  [DEPTH]; // Shift stages
   logic [WIDTH-1:0] stage_next [DEPTH]; // Next stage values

   // Shift by one stage when enabled, else hold
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         stage_next[i] = stage_reg[i];
      end
      if (shiftEn)
      begin
         stage_next[0] = dataIn;
         for (int i = 1; i < DEPTH; i++)
         begin
            stage_next[i] = stage_reg[i-1];
         end
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            stage_reg[i] <= '0;
         end
      end
      else
      begin
         stage_reg <= stage_next;
      end
   end

   assign headOut = stage_reg[0];
   assign tailOut = stage_reg[DEPTH-1];

endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the imaging converter digital side
// Assumes: Far-side pins come from timing_source, moved on falling edges
// Notes:   Table rows hold a code and the word expected after that pixel
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   typedef struct packed
   {
      logic [adc_if_pkg::CODE_W-1:0] code; // Code presented
      logic [adc_if_pkg::CODE_W-1:0] word; // Word expected after that pixel
   } row_s;

   logic                          clk;
   logic                          arst_n;
   logic                          sampleClock, blackClampPulse, preblankPulse, serialClock;
   logic                          serialDataIn, serialLoadN, registerResetN;
   logic [adc_if_pkg::CODE_W-1:0] conversionCode, sampleWordOut;
   logic                          sampleWordOutEn, clampActive;
   logic [7:0]                    clampWidth, controlByte0, controlByte1;
   int                            failures = 0;
   int                            testsRun = 0;
   int                            cycles = 0;
   // Words lag codes by nine pixels; reset fills the pipe with zero
   row_s rows [12] = '{'{14'h2468, 14'h0000}, '{14'h3FFF, 14'h0000}, '{14'h1555, 14'h0000},
                       '{14'h2AAA, 14'h0000}, '{14'h0001, 14'h0000}, '{14'h2000, 14'h0000},
                       '{14'h1FFF, 14'h0000}, '{14'h3FFE, 14'h0000}, '{14'h0ABC, 14'h0000},
                       '{14'h1234, 14'h2468}, '{14'h0F0F, 14'h3FFF}, '{14'h3C3C, 14'h1555}};

   // Far-side model drives every input of the block except clk and arst_n
   timing_source src
   (
      .clk             (clk),
      .sampleClock     (sampleClock),
      .blackClampPulse (blackClampPulse),
      .preblankPulse   (preblankPulse),
      .serialClock     (serialClock),
      .serialDataIn    (serialDataIn),
      .serialLoadN     (serialLoadN),
      .registerResetN  (registerResetN),
      .conversionCode  (conversionCode)
   );

   // Block under test
   imaging_adc_digital_interface uut
   (
      .clk             (clk),
      .arst_n          (arst_n),
      .sampleClock     (sampleClock),
      .blackClampPulse (blackClampPulse),
      .preblankPulse   (preblankPulse),
      .serialClock     (serialClock),
      .serialDataIn    (serialDataIn),
      .serialLoadN     (serialLoadN),
      .registerResetN  (registerResetN),
      .conversionCode  (conversionCode),
      .sampleWordOut   (sampleWordOut),
      .sampleWordOutEn (sampleWordOutEn),
      .clampActive     (clampActive),
      .clampWidth      (clampWidth),
      .controlByte0    (controlByte0),
      .controlByte1    (controlByte1)
   );

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   // 25 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs about 800 cycles; ceiling leaves margin
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      testsRun++;
      if (seen !== expected)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      $display("failures %0d testsRun %0d", failures, testsRun);
      if (failures == 0 && testsRun > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      arst_n = 1'b0;
      repeat (16) @(negedge clk);
      check({2'h0, sampleWordOut}, 16'h0000);
      check({7'h00, sampleWordOutEn, controlByte0}, 16'h0003);
      arst_n = 1'b1;
      src.resetPin(adc_if_pkg::RESET_HOLD_CYC);
      check({controlByte1, controlByte0}, 16'h0003);
      check({14'h0000, sampleWordOutEn, clampActive}, 16'h0002);
      // Ordinary pixels, rising-edge update
      for (int i = 0; i < 12; i++)
      begin
         src.pixel(rows[i].code);
         check({2'h0, sampleWordOut}, {2'h0, rows[i].word});
      end
      // Word holds while the sample clock stands still
      src.hold(20);
      check({2'h0, sampleWordOut}, {2'h0, rows[11].word});
      // Preblank pin is ignored: the next pixel still brings row 3 out
      src.preblank(1'b0);
      src.pixel(14'h0777);
      check({2'h0, sampleWordOut}, {2'h0, rows[3].code});
      src.preblank(1'b1);
      // Clamp counts three pixels, then drops with the pulse
      src.clamp(1'b1);
      for (int i = 0; i < 3; i++)
         src.pixel(14'h2222);
      check({7'h00, clampActive, clampWidth}, 16'h0103);
      src.clamp(1'b0);
      check({7'h00, clampActive, clampWidth}, 16'h0000);
      // Falling-edge update: word trails by eight rises
      src.serialWrite(16'h0013, 8);
      check({controlByte1, controlByte0}, 16'h0013);
      for (int k = 0; k < 10; k++)
      begin
         src.pixel(14'h0100 + 14'(k));
         if (k >= 8)
            check({2'h0, sampleWordOut}, 16'h0100 + 16'(k - 8));
      end
      // Refused frames: part select clear, then a partial byte
      src.serialWrite(16'h0012, 8);
      check({controlByte1, controlByte0}, 16'h0013);
      src.serialWrite(16'h001F, 5);
      check({controlByte1, controlByte0}, 16'h0013);
      // Two bytes: outputs released and clamp disabled under a held pulse
      src.clamp(1'b1);
      src.serialWrite(16'h4081, 16);
      check({controlByte1, controlByte0}, 16'h4081);
      check({14'h0000, sampleWordOutEn, clampActive}, 16'h0000);
      // Reset pin restores defaults; clamp pulse takes effect again
      src.resetPin(6);
      check({controlByte1, controlByte0}, 16'h0003);
      check({14'h0000, sampleWordOutEn, clampActive}, 16'h0003);
      // Second asynchronous reset in mid-run, then a clean return
      arst_n = 1'b0;
      src.hold(2);
      check({2'h0, sampleWordOut}, 16'h0000);
      check({6'h00, sampleWordOutEn, clampActive, clampWidth}, 16'h0000);
      arst_n = 1'b1;
      src.hold(6);
      check({2'h0, sampleWordOut}, 16'h0000);
      check({controlByte1, controlByte0}, 16'h0003);
      check({14'h0000, sampleWordOutEn, clampActive}, 16'h0003);
      report_and_stop();
   end
endmodule

// [timing_source.sv]
// Purpose: Far-side timing source: sample clock, clamp pulse, serial port, reset pin
// Assumes: Every level is held several system clocks so the pin synchronisers see it
// Notes:   Pins move only on the falling edge of clk; idle clocks stand low
`timescale 1ns/1ps
module timing_source
(
   input  wire logic                     clk,
   output logic                          sampleClock,
   output logic                          blackClampPulse,
   output logic                          preblankPulse,
   output logic                          serialClock,
   output logic                          serialDataIn,
   output logic                          serialLoadN,
   output logic                          registerResetN,
   output logic [adc_if_pkg::CODE_W-1:0] conversionCode
);
   // ****************************************
   // Idle levels
   // ****************************************
   initial
   begin
      sampleClock     = 1'b0;     // Stands still between pixels
      blackClampPulse = 1'b0;
      preblankPulse   = 1'b1;     // Pulled up, no effect inside
      serialClock     = 1'b0;     // Stands still between frames
      serialDataIn    = 1'b0;
      serialLoadN     = 1'b1;
      registerResetN  = 1'b1;
      conversionCode  = 14'h0000;
   end

   // ****************************************
   // Pin tasks
   // ****************************************
   // Wait a number of falling edges
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask

   // One pixel; code leads the rise so the synchronised copy is settled
   task automatic pixel(input logic [adc_if_pkg::CODE_W-1:0] code);
      conversionCode = code;
      hold(1);
      sampleClock = 1'b1;
      hold(3);
      sampleClock    = 1'b0;
      conversionCode = ~code; // Sample no longer valid, so no stale value lingers
      hold(4);
   endtask

   // Clamp pulse level; width is counted in pixels by the caller
   task automatic clamp(input logic level);
      blackClampPulse = level;
      hold(4);
   endtask

   // Preblank pin level; the block must ignore it
   task automatic preblank(input logic level);
      preblankPulse = level;
      hold(4);
   endtask

   // Register reset pin pulse of n cycles
   task automatic resetPin(input int n);
      registerResetN = 1'b0;
      hold(n);
      registerResetN = 1'b1;
      hold(4);
   endtask

   // Serial frame: load low, bits LSB first, load high to commit
   task automatic serialWrite(input logic [15:0] data, input int nBits);
      serialLoadN = 1'b0;
      hold(3);
      for (int i = 0; i < nBits; i++)
      begin
         serialDataIn = data[i];
         hold(3);
         serialClock = 1'b1; // Six cycles a bit keeps well under 10 MHz
         hold(3);
         serialClock = 1'b0;
      end
      hold(3);
      serialLoadN  = 1'b1;
      serialDataIn = ~serialDataIn; // Released line shows no stale bit
      hold(6);
   endtask
endmodule
